// File: rtl/decode_pkg.sv
// Purpose: shared constants for the instruction decode and sequencing block
// Assumes: 50 MHz clk_sys, AHB-Lite register access, 32-bit data
// Notes: execution times are held in ns, cycle counts derived and rounded up
package decode_pkg;

  localparam int CLK_NS = 20;

  function automatic int ns2cyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_COND = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CYCLES = 8'h10;
  localparam logic [7:0] OFF_RETIRED = 8'h14;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // mode register fields
  localparam int MODE_EXT = 0;
  localparam int MODE_IND = 1;
  localparam int MODE_LVL = 2;
  localparam int MODE_SHN = 5;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_WAITING = 1;
  localparam int ST_INT_EN = 2;
  localparam int ST_TAKEN = 3;
  localparam int ST_BYTE = 4;
  localparam int ST_REL = 5;
  localparam int ST_RIGHT = 6;
  localparam int ST_DONE = 7;
  localparam int ST_ILLEGAL = 8;
  localparam int ST_CLASS = 9;

  // reset values
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [15:0] COND_RST = 16'h0000;

  // execution times in ns
  localparam int BR_FALL_NS = 1780;
  localparam int BR_TAKEN_NS = 2720;
  localparam int BLT_TAKEN_NS = 3080;
  localparam int BLT_FALL_F_NS = 1880;
  localparam int BLT_FALL_T_NS = 1750;
  localparam int MR_LOGIC_NS = 2500;
  localparam int MR_ARITH_NS = 2790;
  localparam int MR_CMP_NS = 2690;
  localparam int INT_ON_NS = 1850;
  localparam int INT_OFF_NS = 1980;
  localparam int INT_WAIT_NS = 2800;
  localparam int SH_BASE_NS = 2760;
  localparam int SH_BIT_NS = 260;
  localparam int EXT_NS = 130;
  localparam int IND_FIRST_NS = 1140;
  localparam int IND_NEXT_NS = 1010;
  localparam int EXTIND_FIRST_NS = 1400;
  localparam int JMP_NS = 2790;
  localparam int JMP_EXT_NS = 60;
  localparam int JMP_EXTIND_NS = 1330;
  localparam int STORE_STATUS_WORD_ABS_NS = 2140;
  localparam int STORE_STATUS_WORD_REL_NS = 2460;
  localparam int BLOCK_STORE_REGISTERS_ABS_NS = 7240;
  localparam int BLOCK_STORE_REGISTERS_REL_NS = 7560;
  localparam int RETN_ABS_NS = 4240;
  localparam int RETN_REL_NS = 4580;
  localparam int LOAD_STATUS_WORD_ABS_NS = 2470;
  localparam int LOAD_STATUS_WORD_REL_NS = 2790;
  localparam int MREG_ABS_NS = 7930;
  localparam int MREG_REL_NS = 8250;

  // cycle counts
  localparam logic [15:0] BR_FALL_CYC = 16'(ns2cyc(BR_FALL_NS));
  localparam logic [15:0] BR_TAKEN_CYC = 16'(ns2cyc(BR_TAKEN_NS));
  localparam logic [15:0] BLT_TAKEN_CYC = 16'(ns2cyc(BLT_TAKEN_NS));
  localparam logic [15:0] BLT_FALL_F_CYC = 16'(ns2cyc(BLT_FALL_F_NS));
  localparam logic [15:0] BLT_FALL_T_CYC = 16'(ns2cyc(BLT_FALL_T_NS));
  localparam logic [15:0] MR_LOGIC_CYC = 16'(ns2cyc(MR_LOGIC_NS));
  localparam logic [15:0] MR_ARITH_CYC = 16'(ns2cyc(MR_ARITH_NS));
  localparam logic [15:0] MR_CMP_CYC = 16'(ns2cyc(MR_CMP_NS));
  localparam logic [15:0] INT_ON_CYC = 16'(ns2cyc(INT_ON_NS));
  localparam logic [15:0] INT_OFF_CYC = 16'(ns2cyc(INT_OFF_NS));
  localparam logic [15:0] INT_WAIT_CYC = 16'(ns2cyc(INT_WAIT_NS));
  localparam logic [15:0] SH_BASE_CYC = 16'(ns2cyc(SH_BASE_NS));
  localparam logic [15:0] SH_BIT_CYC = 16'(ns2cyc(SH_BIT_NS));
  localparam logic [15:0] EXT_CYC = 16'(ns2cyc(EXT_NS));
  localparam logic [15:0] IND_FIRST_CYC = 16'(ns2cyc(IND_FIRST_NS));
  localparam logic [15:0] IND_NEXT_CYC = 16'(ns2cyc(IND_NEXT_NS));
  localparam logic [15:0] EXTIND_FIRST_CYC = 16'(ns2cyc(EXTIND_FIRST_NS));
  localparam logic [15:0] JMP_CYC = 16'(ns2cyc(JMP_NS));
  localparam logic [15:0] JMP_EXT_CYC = 16'(ns2cyc(JMP_EXT_NS));
  localparam logic [15:0] JMP_EXTIND_CYC = 16'(ns2cyc(JMP_EXTIND_NS));
  localparam logic [15:0] STORE_STATUS_WORD_ABS_CYC = 16'(ns2cyc(STORE_STATUS_WORD_ABS_NS));
  localparam logic [15:0] STORE_STATUS_WORD_REL_CYC = 16'(ns2cyc(STORE_STATUS_WORD_REL_NS));
  localparam logic [15:0] BLOCK_STORE_REGISTERS_ABS_CYC = 16'(ns2cyc(BLOCK_STORE_REGISTERS_ABS_NS));
  localparam logic [15:0] BLOCK_STORE_REGISTERS_REL_CYC = 16'(ns2cyc(BLOCK_STORE_REGISTERS_REL_NS));
  localparam logic [15:0] RETN_ABS_CYC = 16'(ns2cyc(RETN_ABS_NS));
  localparam logic [15:0] RETN_REL_CYC = 16'(ns2cyc(RETN_REL_NS));
  localparam logic [15:0] LOAD_STATUS_WORD_ABS_CYC = 16'(ns2cyc(LOAD_STATUS_WORD_ABS_NS));
  localparam logic [15:0] LOAD_STATUS_WORD_REL_CYC = 16'(ns2cyc(LOAD_STATUS_WORD_REL_NS));
  localparam logic [15:0] MREG_ABS_CYC = 16'(ns2cyc(MREG_ABS_NS));
  localparam logic [15:0] MREG_REL_CYC = 16'(ns2cyc(MREG_REL_NS));

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  typedef enum logic [5:0] {
    CL_BRANCH = 6'b000001,
    CL_SHIFT = 6'b000010,
    CL_CTRL = 6'b000100,
    CL_JUMP = 6'b001000,
    CL_MEMREF = 6'b010000,
    CL_ILLEGAL = 6'b100000
  } cls_t;

endpackage

// File: rtl/bit_sync.sv
// Purpose: two-flop synchroniser for a level from a pin
// Assumes: single clock clk_sys
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module bit_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // level in and out
  input wire logic din,
  output logic dout
);

  logic meta_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule

// File: rtl/exec_timer.sv
// Purpose: down counter that holds an instruction for its execution time
// Assumes: load value of at least one cycle
// Notes: expire is high in the last cycle of the count
`timescale 1ns/1ps
module exec_timer (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // control
  input wire logic load,
  input wire logic [15:0] load_val,
  // status
  output logic expire
);

  logic [15:0] cnt_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 16'h0000;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign expire = (cnt_r == 16'h0001);

endmodule

// File: rtl/instr_decode_top.sv
// Purpose: decode and time one instruction word written over AHB-Lite
// Assumes: single word transfers, registers at byte offsets of decode_pkg
// Notes: zero wait states; execution time is held as a busy window
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module instr_decode_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // processor side
  input wire logic irq_pin,
  output logic int_enable,
  output logic cpu_waiting,
  output logic exec_busy,
  output logic exec_done
);

  // bus capture
  logic ap_valid;
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;

  // programmer state
  logic [15:0] instr_r;
  logic [8:0] mode_r;
  logic [15:0] cond_r;
  logic [31:0] retired_r;

  // decoded and latched results
  decode_pkg::state_t st_r;
  decode_pkg::cls_t cls_r;
  logic [15:0] total_r;
  logic taken_r;
  logic byte_r;
  logic rel_r;
  logic right_r;
  logic int_on_r;
  logic int_off_r;
  logic wait_r;
  logic int_en_r;
  logic done_r;
  logic done_sticky_r;
  logic illegal_sticky_r;

  // decoder outputs
  decode_pkg::cls_t d_cls;
  logic [15:0] d_cyc;
  logic d_taken;
  logic d_byte;
  logic d_rel;
  logic d_right;
  logic d_int_on;
  logic d_int_off;
  logic d_wait;
  logic [15:0] cond_vec;
  logic [3:0] lead;
  logic [3:0] dig2;

  logic start;
  logic expire;
  logic irq_sync;
  logic wr_status;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    return (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  function automatic logic [15:0] addr_extra(input logic [8:0] m, input logic [15:0] ext_c,
                                             input logic [15:0] extind_c);
    logic [15:0] lv;
    lv = {13'h0000, m[decode_pkg::MODE_LVL +: 3]};
    unique case ({m[decode_pkg::MODE_IND], m[decode_pkg::MODE_EXT]})
      2'b01: return ext_c;
      2'b10: return decode_pkg::IND_FIRST_CYC + decode_pkg::IND_NEXT_CYC * lv;
      2'b11: return extind_c + decode_pkg::IND_NEXT_CYC * lv;
      default: return 16'h0000;
    endcase
  endfunction

  bit_sync u_irq_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .din(irq_pin),
    .dout(irq_sync)
  );

  exec_timer u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(start),
    .load_val(d_cyc),
    .expire(expire)
  );

  assign ap_valid = hsel && htrans[1] && hready;
  assign start = dp_wr_r && (dp_addr_r == decode_pkg::OFF_INSTR) && (st_r == decode_pkg::ST_IDLE);
  assign wr_status = dp_wr_r && (dp_addr_r == decode_pkg::OFF_STATUS);
  assign lead = hwdata[15:12];
  assign dig2 = hwdata[11:8];
  assign cond_vec = {cond_r[15:1], 1'b1};

  // bus phase tracking
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= ap_valid && hwrite && (hsize == decode_pkg::HSIZE_WORD) && (haddr[31:8] == 24'h000000);
      dp_addr_r <= haddr[7:0];
    end
  end

  // read data
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata_r <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      hrdata_r <= 32'h00000000;
      if (hit(haddr, decode_pkg::OFF_INSTR)) begin
        hrdata_r <= {16'h0000, instr_r};
      end
      if (hit(haddr, decode_pkg::OFF_MODE)) begin
        hrdata_r <= {23'h000000, mode_r};
      end
      if (hit(haddr, decode_pkg::OFF_COND)) begin
        hrdata_r <= {16'h0000, cond_r};
      end
      if (hit(haddr, decode_pkg::OFF_STATUS)) begin
        hrdata_r <= {17'h00000, cls_r, illegal_sticky_r, done_sticky_r, right_r, rel_r, byte_r,
                     taken_r, int_en_r, st_r[2], st_r[1]};
      end
      if (hit(haddr, decode_pkg::OFF_CYCLES)) begin
        hrdata_r <= {16'h0000, total_r};
      end
      if (hit(haddr, decode_pkg::OFF_RETIRED)) begin
        hrdata_r <= retired_r;
      end
    end
  end

  // steering registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_r <= decode_pkg::MODE_RST;
      cond_r <= decode_pkg::COND_RST;
    end else if (dp_wr_r) begin
      if (dp_addr_r == decode_pkg::OFF_MODE) begin
        mode_r <= hwdata[8:0];
      end
      if (dp_addr_r == decode_pkg::OFF_COND) begin
        cond_r <= hwdata[15:0];
      end
    end
  end

  // instruction decode
  always_comb begin
    d_cls = decode_pkg::CL_ILLEGAL;
    d_cyc = 16'h0001;
    d_taken = 1'b0;
    d_byte = 1'b0;
    d_rel = 1'b0;
    d_right = 1'b0;
    d_int_on = 1'b0;
    d_int_off = 1'b0;
    d_wait = 1'b0;
    if (lead == 4'h8 || lead == 4'h9) begin
      d_cls = decode_pkg::CL_BRANCH;
      d_taken = lead[0] ? cond_vec[dig2] : !cond_vec[dig2];
      if (dig2 == 4'hc) begin
        if (d_taken) begin
          d_cyc = decode_pkg::BLT_TAKEN_CYC;
        end else begin
          d_cyc = lead[0] ? decode_pkg::BLT_FALL_T_CYC : decode_pkg::BLT_FALL_F_CYC;
        end
      end else begin
        d_cyc = d_taken ? decode_pkg::BR_TAKEN_CYC : decode_pkg::BR_FALL_CYC;
      end
    end else if (lead == 4'ha) begin
      if (!dig2[3]) begin
        d_cls = decode_pkg::CL_SHIFT;
        d_right = dig2[2];
        d_cyc = decode_pkg::SH_BASE_CYC + decode_pkg::SH_BIT_CYC * {12'h000, mode_r[decode_pkg::MODE_SHN +: 4]};
      end
    end else if (lead == 4'h0) begin
      d_cls = decode_pkg::CL_CTRL;
      if (dig2 == 4'h8) begin
        unique case (hwdata[7:0])
          8'h00: begin
            d_int_on = 1'b1;
            d_cyc = decode_pkg::INT_ON_CYC;
          end
          8'h40: begin
            d_int_on = 1'b1;
            d_wait = 1'b1;
            d_cyc = decode_pkg::INT_WAIT_CYC;
          end
          8'h80: begin
            d_int_off = 1'b1;
            d_cyc = decode_pkg::INT_OFF_CYC;
          end
          8'hc0: begin
            d_int_off = 1'b1;
            d_wait = 1'b1;
            d_cyc = decode_pkg::INT_WAIT_CYC;
          end
          default: begin
            d_cls = decode_pkg::CL_ILLEGAL;
          end
        endcase
      end else begin
        d_rel = dig2[3];
        unique case (dig2[2:0])
          3'h1: d_cyc = d_rel ? decode_pkg::STORE_STATUS_WORD_REL_CYC : decode_pkg::STORE_STATUS_WORD_ABS_CYC;
          3'h3: d_cyc = d_rel ? decode_pkg::BLOCK_STORE_REGISTERS_REL_CYC : decode_pkg::BLOCK_STORE_REGISTERS_ABS_CYC;
          3'h4: d_cyc = d_rel ? decode_pkg::RETN_REL_CYC : decode_pkg::RETN_ABS_CYC;
          3'h5: d_cyc = d_rel ? decode_pkg::LOAD_STATUS_WORD_REL_CYC : decode_pkg::LOAD_STATUS_WORD_ABS_CYC;
          3'h7: d_cyc = d_rel ? decode_pkg::MREG_REL_CYC : decode_pkg::MREG_ABS_CYC;
          default: begin
            d_cls = decode_pkg::CL_ILLEGAL;
            d_rel = 1'b0;
          end
        endcase
      end
    end else if (lead == 4'h4 && dig2 == 4'h0) begin
      d_cls = decode_pkg::CL_JUMP;
      d_cyc = decode_pkg::JMP_CYC + addr_extra(mode_r, decode_pkg::JMP_EXT_CYC, decode_pkg::JMP_EXTIND_CYC);
    end else begin
      d_cls = decode_pkg::CL_MEMREF;
      d_byte = dig2[3];
      unique case (dig2[2:0])
        3'h1, 3'h2: d_cyc = decode_pkg::MR_ARITH_CYC;
        3'h6: d_cyc = decode_pkg::MR_CMP_CYC;
        default: d_cyc = decode_pkg::MR_LOGIC_CYC;
      endcase
      d_cyc = d_cyc + addr_extra(mode_r, decode_pkg::EXT_CYC, decode_pkg::EXTIND_FIRST_CYC);
    end
  end

  // latch decode results at start
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      instr_r <= decode_pkg::INSTR_RST;
      cls_r <= decode_pkg::CL_ILLEGAL;
      total_r <= 16'h0000;
      taken_r <= 1'b0;
      byte_r <= 1'b0;
      rel_r <= 1'b0;
      right_r <= 1'b0;
      int_on_r <= 1'b0;
      int_off_r <= 1'b0;
      wait_r <= 1'b0;
    end else if (start) begin
      instr_r <= hwdata[15:0];
      cls_r <= d_cls;
      total_r <= d_cyc;
      taken_r <= d_taken;
      byte_r <= d_byte;
      rel_r <= d_rel;
      right_r <= d_right;
      int_on_r <= d_int_on;
      int_off_r <= d_int_off;
      wait_r <= d_wait;
    end
  end

  // sequencing
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= decode_pkg::ST_IDLE;
    end else begin
      unique case (st_r)
        decode_pkg::ST_IDLE: begin
          if (start) begin
            st_r <= decode_pkg::ST_EXEC;
          end
        end
        decode_pkg::ST_EXEC: begin
          if (expire) begin
            st_r <= wait_r ? decode_pkg::ST_WAIT : decode_pkg::ST_IDLE;
          end
        end
        decode_pkg::ST_WAIT: begin
          if (irq_sync) begin
            st_r <= decode_pkg::ST_IDLE;
          end
        end
        default: st_r <= decode_pkg::ST_IDLE;
      endcase
    end
  end

  // interrupt enable and completion flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_en_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= (st_r == decode_pkg::ST_EXEC) && expire;
      if ((st_r == decode_pkg::ST_EXEC) && expire) begin
        if (int_on_r) begin
          int_en_r <= 1'b1;
        end else if (int_off_r) begin
          int_en_r <= 1'b0;
        end
      end
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_sticky_r <= 1'b0;
      illegal_sticky_r <= 1'b0;
      retired_r <= 32'h00000000;
    end else begin
      if ((st_r == decode_pkg::ST_EXEC) && expire) begin
        done_sticky_r <= 1'b1;
        retired_r <= retired_r + 32'h00000001;
      end else if (wr_status && hwdata[decode_pkg::ST_DONE]) begin
        done_sticky_r <= 1'b0;
      end
      if (start && d_cls == decode_pkg::CL_ILLEGAL) begin
        illegal_sticky_r <= 1'b1;
      end else if (wr_status && hwdata[decode_pkg::ST_ILLEGAL]) begin
        illegal_sticky_r <= 1'b0;
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign int_enable = int_en_r;
  assign cpu_waiting = st_r[2];
  assign exec_busy = st_r[1];
  assign exec_done = done_r;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_r01; start && hwdata[15:0] == 16'h8400 |=> taken_r != $past(cond_r[4]); endproperty
  a_r01: assert property (p_r01) else $error("false-sense carry branch wrong");
  property p_r02;
    start && hwdata[15:0] == 16'h9400
    |=> total_r == ($past(cond_r[4]) ? decode_pkg::BR_TAKEN_CYC : decode_pkg::BR_FALL_CYC);
  endproperty
  a_r02: assert property (p_r02) else $error("taken branch time wrong");
  property p_r03;
    start && hwdata[15:0] == 16'h8c00
    |=> total_r == ($past(cond_r[12]) ? decode_pkg::BLT_FALL_F_CYC : decode_pkg::BLT_TAKEN_CYC);
  endproperty
  a_r03: assert property (p_r03) else $error("less branch taken time wrong");
  property p_r04; start && hwdata[15:8] == 8'h1a |=> cls_r == decode_pkg::CL_MEMREF && byte_r; endproperty
  a_r04: assert property (p_r04) else $error("byte memory op not decoded");
  property p_r05; start && hwdata[15:0] == 16'h1600 && mode_r[1:0] == 2'b00 |=> total_r == decode_pkg::MR_CMP_CYC; endproperty
  a_r05: assert property (p_r05) else $error("compare time wrong");
  property p_r06; start && hwdata[15:0] == 16'h0840 |=> ##140 st_r == decode_pkg::ST_WAIT && int_en_r; endproperty
  a_r06: assert property (p_r06) else $error("enable and wait wrong");
  property p_r07; start && hwdata[15:0] == 16'h0880 |=> int_off_r ##98 int_enable ##1 !int_enable; endproperty
  a_r07: assert property (p_r07) else $error("disable not applied at end");
  property p_r08; start && hwdata[15:8] == 8'ha2 |=> total_r == decode_pkg::SH_BASE_CYC + decode_pkg::SH_BIT_CYC * {12'h000, $past(mode_r[8:5])}; endproperty
  a_r08: assert property (p_r08) else $error("left shift time wrong");
  property p_r09; start && hwdata[15:10] == 6'h29 |=> right_r && cls_r == decode_pkg::CL_SHIFT; endproperty
  a_r09: assert property (p_r09) else $error("right shift not decoded");
  property p_r10; start && hwdata[15:0] == 16'h0c00 |=> rel_r && total_r == decode_pkg::RETN_REL_CYC; endproperty
  a_r10: assert property (p_r10) else $error("relative return wrong");
  property p_r11;
    start && hwdata[15:8] == 8'h1a && mode_r[1:0] == 2'b01
    |=> total_r == decode_pkg::MR_ARITH_CYC + decode_pkg::EXT_CYC;
  endproperty
  a_r11: assert property (p_r11) else $error("extended adder wrong");
  property p_r12;
    start && hwdata[15:0] == 16'h1000 && mode_r[4:0] == 5'b01010
    |=> total_r == decode_pkg::MR_LOGIC_CYC + decode_pkg::IND_FIRST_CYC + decode_pkg::IND_NEXT_CYC * 16'h0002;
  endproperty
  a_r12: assert property (p_r12) else $error("indirect adder wrong");
  property p_r13;
    start && hwdata[15:0] == 16'h1000 && mode_r[4:0] == 5'b00011
    |=> total_r == decode_pkg::MR_LOGIC_CYC + decode_pkg::EXTIND_FIRST_CYC;
  endproperty
  a_r13: assert property (p_r13) else $error("extended indirect adder wrong");
  property p_r14; start && hwdata[15:0] == 16'h4000 && mode_r[1:0] == 2'b01 |=> total_r == decode_pkg::JMP_CYC + decode_pkg::JMP_EXT_CYC; endproperty
  a_r14: assert property (p_r14) else $error("extended jump time wrong");

endmodule

// File: tb/irq_partner.sv
// Purpose: processor-side interrupt source facing the decode block
// Assumes: request raised only while the block sits in its wait state
// Notes: drops the request as soon as the wait ends
`timescale 1ns/1ps
module irq_partner #(
  parameter int DLY = 5
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // wait handshake
  input wire logic cpu_waiting,
  output logic irq_pin = 1'b0
);
  int cnt = 0;
  // request after a delay of waiting
  always @(posedge clk_sys) begin
    if (reset || !cpu_waiting) begin
      cnt <= 0;
      irq_pin <= 1'b0;
    end else begin
      if (cnt < DLY) cnt <= cnt + 1;
      irq_pin <= (cnt >= DLY);
    end
  end
endmodule

// File: tb/minicomputer_instruction_decode_tb_top.sv
// Purpose: self-checking bench for instr_decode_top
// Assumes: zero wait state slave, 50 MHz clk_sys
// Notes: table rows give instruction, mode, conditions and expected timing
`timescale 1ns/1ps
module minicomputer_instruction_decode_tb_top;
  typedef struct packed {
    logic [15:0] ins; logic [8:0] md; logic [15:0] cd; logic [15:0] cyc; logic ie; logic w;
  } row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = decode_pkg::HSIZE_WORD;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq_pin, int_enable, cpu_waiting, exec_busy, exec_done;
  wire logic hready = hreadyout;
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int n;
  row_t rows [18] = '{
    '{16'h8400, 9'h0, 16'h0, 16'd136, 1'b0, 1'b0}, '{16'h9400, 9'h0, 16'h0, 16'd89, 1'b0, 1'b0},
    '{16'h9c00, 9'h0, 16'h1000, 16'd154, 1'b0, 1'b0}, '{16'h8c00, 9'h0, 16'h1000, 16'd94, 1'b0, 1'b0},
    '{16'h9200, 9'h0, 16'h0004, 16'd136, 1'b0, 1'b0}, '{16'h1200, 9'h0, 16'h0, 16'd140, 1'b0, 1'b0},
    '{16'h1600, 9'h0, 16'h0, 16'd135, 1'b0, 1'b0}, '{16'h1a00, 9'h001, 16'h0, 16'd147, 1'b0, 1'b0},
    '{16'h1000, 9'h00a, 16'h0, 16'd284, 1'b0, 1'b0}, '{16'h1000, 9'h003, 16'h0, 16'd195, 1'b0, 1'b0},
    '{16'h4000, 9'h001, 16'h0, 16'd143, 1'b0, 1'b0}, '{16'ha200, 9'h060, 16'h0, 16'd177, 1'b0, 1'b0},
    '{16'ha500, 9'h0, 16'h0, 16'd138, 1'b0, 1'b0}, '{16'h0c00, 9'h0, 16'h0, 16'd229, 1'b0, 1'b0},
    '{16'h0840, 9'h0, 16'h0, 16'd140, 1'b1, 1'b1}, '{16'h08c0, 9'h0, 16'h0, 16'd140, 1'b0, 1'b1},
    '{16'h0800, 9'h0, 16'h0, 16'd93, 1'b1, 1'b0}, '{16'h0880, 9'h0, 16'h0, 16'd99, 1'b0, 1'b0}};

  instr_decode_top dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq_pin(irq_pin), .int_enable(int_enable), .cpu_waiting(cpu_waiting),
    .exec_busy(exec_busy), .exec_done(exec_done));
  irq_partner partner (.clk_sys(clk_sys), .reset(reset), .cpu_waiting(cpu_waiting), .irq_pin(irq_pin));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // count busy cycles, land on the cycle after
  task run_busy;
    n = 0;
    @(posedge clk_sys);
    while (exec_busy === 1'b1 && n < 3000) begin
      n++;
      @(posedge clk_sys);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    chk(hrdata, 32'h0);
    chk(32'(int_enable), 32'h0);
    chk({cpu_waiting, exec_busy, exec_done, hresp, hreadyout}, 32'h1);
    bus(1'b0, 32'(decode_pkg::OFF_INSTR), 32'h0, rd);
    chk(rd, 32'(decode_pkg::INSTR_RST));
    $display("reset test done");
    for (int i = 0; i < 18; i++) begin
      bus(1'b1, 32'(decode_pkg::OFF_MODE), 32'(rows[i].md), rd);
      bus(1'b1, 32'(decode_pkg::OFF_COND), 32'(rows[i].cd), rd);
      bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'(rows[i].ins), rd);
      run_busy();
      chk(32'(n), 32'(rows[i].cyc));
      chk(32'(exec_done), 32'h1);
      if (rows[i].w) begin
        chk(32'(cpu_waiting), 32'h1);
        n = 0;
        while (cpu_waiting === 1'b1 && n < 40) begin
          n++;
          @(posedge clk_sys);
        end
        chk(32'(cpu_waiting), 32'h0);
      end
      chk(32'(int_enable), 32'(rows[i].ie));
      bus(1'b0, 32'(decode_pkg::OFF_CYCLES), 32'h0, rd);
      chk(rd, 32'(rows[i].cyc));
      $display("row %0d test done", i);
    end
    bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'h1200, rd);
    bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'h0800, rd);
    run_busy();
    chk(32'(n), 32'd138);
    chk(32'(int_enable), 32'h0);
    bus(1'b0, 32'(decode_pkg::OFF_INSTR), 32'h0, rd);
    chk(rd, 32'h1200);
    $display("refused start test done");
    bus(1'b0, 32'h100, 32'h0, rd);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("unmapped test done");
    bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'h0600, rd);
    run_busy();
    chk(32'(n), 32'h1);
    bus(1'b0, 32'(decode_pkg::OFF_STATUS), 32'h0, rd);
    chk(rd, 32'h4180);
    bus(1'b1, 32'(decode_pkg::OFF_STATUS), 32'h180, rd);
    bus(1'b0, 32'(decode_pkg::OFF_STATUS), 32'h0, rd);
    chk(rd, 32'h4000);
    bus(1'b0, 32'(decode_pkg::OFF_RETIRED), 32'h0, rd);
    chk(rd, 32'd20);
    hsize <= 3'h0;
    bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'h1200, rd);
    hsize <= decode_pkg::HSIZE_WORD;
    bus(1'b0, 32'(decode_pkg::OFF_INSTR), 32'h0, rd);
    chk(rd, 32'h0600);
    chk(32'(exec_busy), 32'h0);
    $display("illegal and status test done");
    bus(1'b1, 32'(decode_pkg::OFF_INSTR), 32'h0840, rd);
    repeat (5) @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({exec_busy, cpu_waiting, int_enable, exec_done}, 32'h0);
    bus(1'b0, 32'(decode_pkg::OFF_INSTR), 32'h0, rd);
    chk(rd, 32'(decode_pkg::INSTR_RST));
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
